// ==== hdl/osc_ctrl_map.vh ====
// Purpose: constants for the oscillator select and clock divider block
// Assumes: registers are 16 bits wide, reached over a plain strobe port
// Notes: offsets are word indices on the register port
`ifndef OSC_CTRL_MAP_VH
`define OSC_CTRL_MAP_VH
`define OFS_OSC_CTRL      2'h0
`define OFS_CLK_DIV       2'h1
`define OFS_RC_TUNE       2'h2
`define SRC_FRC           3'h0
`define SRC_FRC_PLL       3'h1
`define SRC_PRI           3'h2
`define SRC_PRI_PLL       3'h3
`define SRC_SEC           3'h4
`define SRC_LOW_POWER_INTERNAL_RC          3'h5
`define SRC_LPFRC_DIV     3'h6
`define SRC_FRC_DIV       3'h7
`define PMODE_EXT         2'h0
`define PMODE_XT          2'h1
`define PMODE_HS          2'h2
`define BIT_CUR_LO        12
`define BIT_NEW_LO        8
`define BIT_SEL_LOCK      7
`define BIT_PLL_LOCK      5
`define BIT_FAIL          3
`define BIT_DRIVE         2
`define BIT_SEC_EN        1
`define BIT_REQ           0
`define BIT_ROI           15
`define BIT_RATIO_LO      12
`define BIT_SLOW_EN       11
`define BIT_POST_LO       8
`define RST_RATIO         3'h3
`define RST_POST          3'h1
`define UNLK_HI_A         8'h78
`define UNLK_HI_B         8'h9a
`define UNLK_LO_A         8'h46
`define UNLK_LO_B         8'h57
`define SETTLE_CYC        4'ha
`define SYNC_FILL         2'h3
`define ST_IDLE           2'h0
`define ST_WAIT_RDY       2'h1
`define ST_SETTLE         2'h2
`endif

// ==== hdl/osc_select_ctrl.v ====
// Purpose: oscillator select, switch sequencing and clock divider control
// Assumes: ref_clk is the selected system clock; config strapped at reset release
// Notes: unlock keys are checked on the byte written to the addressed byte lane
`timescale 1ns/1ps
`include "osc_ctrl_map.vh"
module osc_select_ctrl (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [1:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire [1:0]  reg_be,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [1:0]  primary_mode_config,
  input  wire [2:0]  initial_source_config,
  input  wire [1:0]  external_clock_range_config,
  input  wire [1:0]  switch_monitor_config,
  input  wire        secondary_input_type_config,
  input  wire        osc_ready,
  input  wire        pll_locked,
  input  wire        clock_fail_event,
  input  wire        irq_event,
  input  wire        new_clk_tick,
  output reg  [2:0]  active_source,
  output reg  [1:0]  primary_submode,
  output reg  [1:0]  ext_range,
  output reg         pll_enable,
  output reg         frc_enable,
  output reg         lpfrc_enable,
  output reg         low_power_internal_rc_enable,
  output reg         primary_enable,
  output reg         secondary_enable,
  output reg         secondary_high_power,
  output reg         monitor_enable,
  output reg  [2:0]  frc_postscale,
  output reg  [5:0]  frc_trim,
  output reg         cpu_clk_en
);
  // strap levels and oscillator status cross in through level filters
  reg         cfg_ok_r;
  reg  [10:0] cfg_r;
  reg         lock_r;
  wire [10:0] cfg_q;
  wire        cfg_settled;
  wire [1:0]  sts_q;
  wire [10:0] cfg_raw = {secondary_input_type_config, switch_monitor_config,
                         external_clock_range_config, primary_mode_config,
                         initial_source_config, 1'b0};
  // captured strap fields; bit 0 is a spare zero
  wire [1:0]  cfg_pmode    = cfg_r[5:4];
  wire [1:0]  cfg_range    = cfg_r[7:6];
  wire [1:0]  cfg_swmon    = cfg_r[9:8];
  wire        cfg_sec_xtal = cfg_r[10];
  wire        sw_en        = ~cfg_swmon[1];
  wire        mon_en       = (cfg_swmon == 2'b00);
  wire        sel_frozen   = mon_en & lock_r;
  // status levels come from the analog side
  wire        osc_ready_q  = sts_q[1];
  wire        pll_locked_q = sts_q[0];

  // straps are read once, after every stage holds post-release samples
  level_filter #(
    .WIDTH   (11)
  ) i_cfg_filter (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (cfg_raw),
    .dout    (cfg_q),
    .settled (cfg_settled)
  );

  // a ready or lock level that flickers for one cycle is not believed
  level_filter #(
    .WIDTH   (2)
  ) i_sts_filter (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     ({osc_ready, pll_locked}),
    .dout    (sts_q),
    .settled ()
  );

  // oscillator control fields
  reg [2:0] cur_r, new_r;
  reg       req_r, pll_lk_r, fail_r, drive_r, sec_en_r;
  reg [1:0] st_r;
  reg [3:0] settle_r;
  reg       unlk_hi_r, unlk_lo_r;
  reg       key_hi_r, key_lo_r;
  reg       roi_r, slow_r;
  reg [2:0] ratio_r, post_r;
  reg [5:0] trim_r;
  reg [6:0] cpu_cnt_r;

  wire wr_osc = reg_wr & (reg_addr == `OFS_OSC_CTRL);
  wire wr_div = reg_wr & (reg_addr == `OFS_CLK_DIV);
  wire wr_tun = reg_wr & (reg_addr == `OFS_RC_TUNE);
  wire [7:0] wb_hi = reg_wdata[15:8];
  wire [7:0] wb_lo = reg_wdata[7:0];
  wire hi_key_a = wr_osc & reg_be[1] & (wb_hi == `UNLK_HI_A);
  wire hi_key_b = wr_osc & reg_be[1] & (wb_hi == `UNLK_HI_B);
  wire lo_key_a = wr_osc & reg_be[0] & (wb_lo == `UNLK_LO_A);
  wire lo_key_b = wr_osc & reg_be[0] & (wb_lo == `UNLK_LO_B);
  wire hi_wr_ok = wr_osc & reg_be[1] & unlk_hi_r & ~hi_key_a;
  wire lo_wr_ok = wr_osc & reg_be[0] & unlk_lo_r & ~lo_key_a;
  wire uses_pll = (cur_r == `SRC_PRI_PLL) | (cur_r == `SRC_FRC_PLL);
  wire tgt_pll  = (new_r == `SRC_PRI_PLL) | (new_r == `SRC_FRC_PLL);
  wire ready_ok = osc_ready_q & (~tgt_pll | pll_locked_q);

  // unlock tracking: a key pair must land on back-to-back writes
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      key_hi_r  <= 1'b0;
      key_lo_r  <= 1'b0;
      unlk_hi_r <= 1'b0;
      unlk_lo_r <= 1'b0;
    end else if (reg_wr) begin
      key_hi_r  <= hi_key_a;
      key_lo_r  <= lo_key_a;
      unlk_hi_r <= key_hi_r & hi_key_b;
      unlk_lo_r <= key_lo_r & lo_key_b;
    end
  end

  // switch sequencer, config capture and control bits
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ok_r <= 1'b0;
      cfg_r    <= 11'h7fe;
      cur_r    <= `SRC_FRC_DIV;
      new_r    <= `SRC_FRC_DIV;
      req_r    <= 1'b0;
      lock_r   <= 1'b0;
      pll_lk_r <= 1'b0;
      fail_r   <= 1'b0;
      drive_r  <= 1'b0;
      sec_en_r <= 1'b0;
      st_r     <= `ST_IDLE;
      settle_r <= 4'h0;
    end else if (!cfg_ok_r) begin
      // catch the strapped config once it is settled after release
      if (cfg_settled) begin
        cfg_ok_r <= 1'b1;
        cfg_r    <= cfg_q;
        cur_r    <= cfg_q[3:1];
        new_r    <= cfg_q[3:1];
      end
    end else begin
      if (hi_wr_ok & ~sel_frozen & (st_r == `ST_IDLE))
        new_r <= wb_hi[2:0];
      if (lo_wr_ok) begin
        if (wb_lo[`BIT_SEL_LOCK])
          lock_r <= 1'b1;
        drive_r  <= wb_lo[`BIT_DRIVE];
        sec_en_r <= wb_lo[`BIT_SEC_EN];
      end
      // hardware set wins over the software clear
      if (clock_fail_event & mon_en)
        fail_r <= 1'b1;
      else if (lo_wr_ok & ~wb_lo[`BIT_FAIL])
        fail_r <= 1'b0;
      // pll lock status follows the active mode
      if (!uses_pll)
        pll_lk_r <= 1'b0;
      else
        pll_lk_r <= pll_locked_q;
      case (st_r)
        `ST_IDLE: begin
          if (lo_wr_ok & wb_lo[`BIT_REQ] & sw_en & ~sel_frozen) begin
            if (new_r == cur_r) begin
              req_r <= 1'b0;
            end else begin
              req_r    <= 1'b1;
              pll_lk_r <= 1'b0;
              fail_r   <= clock_fail_event & mon_en;
              st_r     <= `ST_WAIT_RDY;
            end
          end
        end
        `ST_WAIT_RDY: begin
          if (ready_ok) begin
            settle_r <= 4'h0;
            st_r     <= `ST_SETTLE;
          end
        end
        `ST_SETTLE: begin
          if (new_clk_tick)
            settle_r <= settle_r + 4'h1;
          if (new_clk_tick & (settle_r == `SETTLE_CYC - 4'h1)) begin
            cur_r <= new_r;
            req_r <= 1'b0;
            st_r  <= `ST_IDLE;
          end
        end
        default: st_r <= `ST_IDLE;
      endcase
    end
  end

  // divider and trim registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      roi_r   <= 1'b0;
      slow_r  <= 1'b0;
      ratio_r <= `RST_RATIO;
      post_r  <= `RST_POST;
      trim_r  <= 6'h00;
    end else begin
      if (wr_div & reg_be[1]) begin
        roi_r   <= reg_wdata[`BIT_ROI];
        ratio_r <= reg_wdata[`BIT_RATIO_LO+2:`BIT_RATIO_LO];
        post_r  <= reg_wdata[`BIT_POST_LO+2:`BIT_POST_LO];
      end
      // interrupt recovery beats a software set
      if (roi_r & irq_event)
        slow_r <= 1'b0;
      else if (wr_div & reg_be[1])
        slow_r <= reg_wdata[`BIT_SLOW_EN];
      if (wr_tun & reg_be[0])
        trim_r <= reg_wdata[5:0];
    end
  end

  // cpu clock enable: one pulse every 2^ratio cycles when slowed
  wire [6:0] ratio_mask = (7'h01 << ratio_r) - 7'h01;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_cnt_r  <= 7'h00;
      cpu_clk_en <= 1'b1;
    end else if (!slow_r) begin
      cpu_cnt_r  <= 7'h00;
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_cnt_r  <= (cpu_cnt_r + 7'h01) & ratio_mask;
      cpu_clk_en <= (cpu_cnt_r == ratio_mask);
    end
  end

  // oscillator enables decoded from the active and the target source;
  // the target is started early so it can settle before the change-over
  reg [1:0] ext_range_nxt;
  reg       pll_enable_nxt, frc_enable_nxt, lpfrc_enable_nxt;
  reg       low_power_internal_rc_enable_nxt, primary_enable_nxt;
  reg       secondary_enable_nxt, high_power_nxt;
  always @* begin
    ext_range_nxt        = cfg_range;
    pll_enable_nxt       = uses_pll;
    frc_enable_nxt       = 1'b0;
    lpfrc_enable_nxt     = 1'b0;
    low_power_internal_rc_enable_nxt      = mon_en;
    primary_enable_nxt   = 1'b0;
    secondary_enable_nxt = sec_en_r;
    // drive bit is ignored when the secondary pins carry a digital clock
    high_power_nxt       = drive_r & cfg_sec_xtal;
    case (cur_r)
      `SRC_FRC:       frc_enable_nxt       = 1'b1;
      `SRC_FRC_PLL:   frc_enable_nxt       = 1'b1;
      `SRC_FRC_DIV:   frc_enable_nxt       = 1'b1;
      `SRC_PRI:       primary_enable_nxt   = 1'b1;
      `SRC_PRI_PLL:   primary_enable_nxt   = 1'b1;
      `SRC_SEC:       secondary_enable_nxt = 1'b1;
      `SRC_LOW_POWER_INTERNAL_RC:      low_power_internal_rc_enable_nxt      = 1'b1;
      `SRC_LPFRC_DIV: lpfrc_enable_nxt     = 1'b1;
      default:        frc_enable_nxt       = 1'b1;
    endcase
    if (st_r != `ST_IDLE) begin
      if (tgt_pll)
        pll_enable_nxt = 1'b1;
      case (new_r)
        `SRC_FRC:       frc_enable_nxt       = 1'b1;
        `SRC_FRC_PLL:   frc_enable_nxt       = 1'b1;
        `SRC_FRC_DIV:   frc_enable_nxt       = 1'b1;
        `SRC_PRI:       primary_enable_nxt   = 1'b1;
        `SRC_PRI_PLL:   primary_enable_nxt   = 1'b1;
        `SRC_SEC:       secondary_enable_nxt = 1'b1;
        `SRC_LOW_POWER_INTERNAL_RC:      low_power_internal_rc_enable_nxt      = 1'b1;
        `SRC_LPFRC_DIV: lpfrc_enable_nxt     = 1'b1;
        default:        frc_enable_nxt       = 1'b1;
      endcase
    end
  end

  // every output leaves straight from a flop
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active_source        <= `SRC_FRC_DIV;
      primary_submode      <= `PMODE_EXT;
      ext_range            <= 2'h3;
      pll_enable           <= 1'b0;
      frc_enable           <= 1'b1;
      lpfrc_enable         <= 1'b0;
      low_power_internal_rc_enable          <= 1'b0;
      primary_enable       <= 1'b0;
      secondary_enable     <= 1'b0;
      secondary_high_power <= 1'b0;
      monitor_enable       <= 1'b0;
      frc_postscale        <= `RST_POST;
      frc_trim             <= 6'h00;
    end else begin
      active_source        <= cur_r;
      primary_submode      <= cfg_pmode;
      ext_range            <= ext_range_nxt;
      pll_enable           <= pll_enable_nxt;
      frc_enable           <= frc_enable_nxt;
      lpfrc_enable         <= lpfrc_enable_nxt;
      low_power_internal_rc_enable          <= low_power_internal_rc_enable_nxt;
      primary_enable       <= primary_enable_nxt;
      secondary_enable     <= secondary_enable_nxt;
      secondary_high_power <= high_power_nxt;
      monitor_enable       <= mon_en;
      frc_postscale        <= post_r;
      frc_trim             <= trim_r;
    end
  end

  // read mux, unmapped and unimplemented bits read as zero
  reg [15:0] rdata_nxt;
  always @* begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_OSC_CTRL: rdata_nxt = {1'b0, cur_r, 1'b0, new_r, lock_r, 1'b0,
                                    pll_lk_r, 1'b0, fail_r, drive_r, sec_en_r,
                                    req_r};
        `OFS_CLK_DIV:  rdata_nxt = {roi_r, ratio_r, slow_r, post_r, 8'h00};
        `OFS_RC_TUNE:  rdata_nxt = {10'h000, trim_r};
        default:       rdata_nxt = 16'h0000;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= rdata_nxt;
  end
endmodule

// three-stage filter for levels from another clock domain; a bit moves
// only when the second and third stages agree, so short glitches drop out
module level_filter #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout,
  output reg              settled
);
  reg [WIDTH-1:0] s1_r, s2_r, s3_r;
  reg [1:0]       fill_r;
  wire            full = (fill_r == `SYNC_FILL);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r    <= {WIDTH{1'b0}};
      s2_r    <= {WIDTH{1'b0}};
      s3_r    <= {WIDTH{1'b0}};
      fill_r  <= 2'h0;
      dout    <= {WIDTH{1'b0}};
      settled <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (!full)
        fill_r <= fill_r + 2'h1;
      // until the stages fill, their equal contents are reset leftovers
      settled <= full & (s2_r == s3_r);
      dout    <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule

// ==== verification/osc_select_assertions.sv ====
// Purpose: port-level checks for the oscillator select block
// Assumes: strap inputs held steady once reset is released
// Notes: bound to every osc_select_ctrl instance
`timescale 1ns/1ps
module osc_select_checker (
  input wire        ref_clk,
  input wire        nrst,
  input wire [1:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire [1:0]  external_clock_range_config,
  input wire [1:0]  switch_monitor_config,
  input wire        new_clk_tick,
  input wire [2:0]  active_source,
  input wire [1:0]  ext_range,
  input wire        monitor_enable,
  input wire [2:0]  frc_postscale,
  input wire [5:0]  frc_trim,
  input wire        cpu_clk_en
);
  reg  [3:0] up_cnt;
  reg  [7:0] low_cnt;
  wire       wr_div  = reg_wr && reg_addr == 2'h1;
  wire       wr_tune = reg_wr && reg_addr == 2'h2;
  // wait out strap capture; count cpu enable gaps
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      up_cnt  <= 4'h0;
      low_cnt <= 8'h00;
    end else begin
      if (up_cnt != 4'h8)
        up_cnt <= up_cnt + 4'h1;
      low_cnt <= cpu_clk_en ? 8'h00 : low_cnt + 8'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence rd_at(logic [1:0] a);
    reg_rd && reg_addr == a;
  endsequence
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero when idle");
  AST_UNMAPPED: assert property (rd_at(2'h3) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_OSC_RSVD: assert property (rd_at(2'h0) |=> (reg_rdata & 16'h8850) == 16'h0000)
    else $error("unused control bits read nonzero");
  AST_TRIM_CHG: assert property ($changed(frc_trim) |-> $past(wr_tune) || $past(wr_tune, 2))
    else $error("trim changed without a write");
  AST_POST_CHG: assert property ($changed(frc_postscale) |-> $past(wr_div) || $past(wr_div, 2))
    else $error("postscaler changed without a write");
  AST_SRC_STEADY: assert property (up_cnt == 4'h8 && $changed(active_source) |->
    $past(new_clk_tick, 2) || $past(new_clk_tick, 3)) else $error("source moved without ticks");
  AST_LOW_RUN: assert property (low_cnt < 8'd128)
    else $error("cpu enable gap too long");
  AST_MON: assert property (up_cnt == 4'h8 |-> monitor_enable == (switch_monitor_config == 2'b00))
    else $error("monitor enable wrong");
  AST_RANGE: assert property (up_cnt == 4'h8 |-> ext_range == external_clock_range_config)
    else $error("range output wrong");
endmodule
bind osc_select_ctrl osc_select_checker i_osc_select_checker (.ref_clk, .nrst, .reg_addr,
  .reg_wr, .reg_rd, .reg_rdata, .external_clock_range_config, .switch_monitor_config,
  .new_clk_tick, .active_source, .ext_range, .monitor_enable, .frc_postscale, .frc_trim,
  .cpu_clk_en);

// ==== verification/testbench.sv ====
// Purpose: directed register and switch tests for the oscillator select block
// Assumes: unprogrammed straps except switching and monitor enabled
// Notes: oscillator stays ready, so each switch waits only for ticks
`timescale 1ns/1ps
module testbench;
  reg         ref_clk, nrst, reg_wr, reg_rd, osc_ready, pll_locked;
  reg         clock_fail_event, irq_event, new_clk_tick;
  reg  [1:0]  reg_addr, reg_be, sw_mon;
  reg  [15:0] reg_wdata, rdv;
  wire [15:0] reg_rdata;
  wire [2:0]  active_source, frc_postscale;
  wire [1:0]  primary_submode, ext_range;
  wire [5:0]  frc_trim;
  wire        pll_enable, frc_enable, lpfrc_enable, low_power_internal_rc_enable, primary_enable;
  wire        secondary_enable, secondary_high_power, monitor_enable, cpu_clk_en;
  integer     num_errors, comparisons, n;
  osc_select_ctrl i_osc_select_ctrl (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_be, .reg_rd, .reg_rdata, .primary_mode_config(2'b11), .initial_source_config(3'h7),
    .external_clock_range_config(2'b11), .switch_monitor_config(sw_mon),
    .secondary_input_type_config(1'b1), .osc_ready, .pll_locked, .clock_fail_event,
    .irq_event, .new_clk_tick, .active_source, .primary_submode, .ext_range, .pll_enable,
    .frc_enable, .lpfrc_enable, .low_power_internal_rc_enable, .primary_enable, .secondary_enable,
    .secondary_high_power, .monitor_enable, .frc_postscale, .frc_trim, .cpu_clk_en);
  always #2 ref_clk = ~ref_clk;
  task wrap_up;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one write cycle, strobe released on the taking edge
  task wr(input [1:0] a, input [15:0] d, input [1:0] be);
    begin
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      reg_be    <= be;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
    end
  endtask
  // one read cycle, data taken in the cycle after the strobe
  task rdq(input [1:0] a);
    begin
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 rdv = reg_rdata;
    end
  endtask
  task chkrd(input [1:0] a, input [15:0] exp);
    begin
      rdq(a);
      chk(rdv, exp);
    end
  endtask
  // restart mid-run with other switch and monitor straps
  task restart(input [1:0] sm);
    begin
      @(posedge ref_clk);
      nrst   <= 1'b0;
      sw_mon <= sm;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  // key pair then data, strobe held high so the three writes are consecutive
  task ul(input hi, input [15:0] d);
    begin
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= 2'h0;
      reg_be    <= hi ? 2'b10 : 2'b01;
      reg_wdata <= hi ? 16'h7800 : 16'h0046;
      @(posedge ref_clk);
      reg_wdata <= hi ? 16'h9a00 : 16'h0057;
      @(posedge ref_clk);
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
    end
  endtask
  task cnt(input integer k);
    begin
      n = 0;
      repeat (k) begin
        @(posedge ref_clk);
        #1;
        if (cpu_clk_en === 1'b1)
          n = n + 1;
      end
    end
  endtask
  task t_reset;
    begin
      chk({active_source, frc_postscale, ext_range, monitor_enable, frc_enable}, 16'h039f);
      chkrd(2'h0, 16'h7700);
      chkrd(2'h1, 16'h3100);
      chkrd(2'h3, 16'h0000);
      wr(2'h2, 16'hffff, 2'b11);
      chkrd(2'h2, 16'h003f);
      $display("reset and tune done");
    end
  endtask
  task t_div;
    begin
      wr(2'h1, 16'hffff, 2'b11);
      chkrd(2'h1, 16'hff00);
      chk(frc_postscale, 16'h0007);
      cnt(256);
      chk(n, 16'h0002);
      @(posedge ref_clk);
      irq_event <= 1'b1;
      @(posedge ref_clk);
      irq_event <= 1'b0;
      chkrd(2'h1, 16'hf700);
      wr(2'h1, 16'h7000, 2'b11);
      cnt(16);
      chk(n, 16'h0010);
      $display("divider done");
    end
  endtask
  task t_switch;
    begin
      wr(2'h0, 16'h0500, 2'b10);
      chkrd(2'h0, 16'h7700);
      ul(1'b1, 16'h0000);
      ul(1'b0, 16'h0001);
      chkrd(2'h0, 16'h7001);
      @(posedge ref_clk);
      new_clk_tick <= 1'b1;
      repeat (10) @(posedge ref_clk);
      new_clk_tick <= 1'b0;
      n = 0;
      rdv = 16'h0001;
      while (rdv[0] !== 1'b0 && n < 20) begin
        rdq(2'h0);
        n = n + 1;
      end
      if (rdv[0] !== 1'b0) begin
        num_errors = num_errors + 1;
        wrap_up;
      end
      chkrd(2'h0, 16'h0000);
      chk(active_source, 16'h0000);
      chk({primary_submode, pll_enable, lpfrc_enable, low_power_internal_rc_enable, primary_enable, frc_enable},
          16'h0065);
      ul(1'b0, 16'h0001);
      chkrd(2'h0, 16'h0000);
      $display("switch done");
    end
  endtask
  task t_flags;
    begin
      @(posedge ref_clk);
      clock_fail_event <= 1'b1;
      @(posedge ref_clk);
      clock_fail_event <= 1'b0;
      chkrd(2'h0, 16'h0008);
      ul(1'b0, 16'h0006);
      chkrd(2'h0, 16'h0006);
      chk({secondary_enable, secondary_high_power}, 16'h0003);
      ul(1'b0, 16'h0086);
      ul(1'b1, 16'h0700);
      chkrd(2'h0, 16'h0086);
      $display("flags done");
    end
  endtask
  task t_modes;
    begin
      restart(2'b01);
      chk(monitor_enable, 16'h0000);
      ul(1'b0, 16'h0080);
      ul(1'b1, 16'h0000);
      ul(1'b0, 16'h0081);
      chkrd(2'h0, 16'h7081);
      restart(2'b10);
      ul(1'b1, 16'h0000);
      ul(1'b0, 16'h0001);
      chkrd(2'h0, 16'h7000);
      $display("modes done");
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    {ref_clk, nrst, reg_wr, reg_rd, pll_locked, clock_fail_event, irq_event} = 7'h0;
    {new_clk_tick, reg_addr, reg_be, reg_wdata, rdv} = 37'h0;
    osc_ready = 1'b1;
    sw_mon = 2'b00;
    num_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_reset;
    t_div;
    t_switch;
    t_flags;
    t_modes;
    wrap_up;
  end
endmodule
